// [hw/rph_top.sv]
// Receive packet handler: continuous pins, packet framing, filters, FIFO
// Notes on behaviour
// - Without bit sync, raw demodulator bits go to data pin, no clock.
// - With bit sync, clean data changes on clock fall; host samples on rise.
// - Bit sync is forced on in packet mode.
// - Packet mode keeps bits off the pins and fills the FIFO.
// - Format bit 0 with nonzero length selects fixed length, no length byte.
// - Fixed payload up to 255 bytes, or 64/65 with decryption.
// - Fixed length counts message plus address; at least one byte.
// - Format bit 1 selects variable length; first byte gives the length.
// - Variable payload has length byte plus at least one more byte.
// - Format 0 with length 0 is unlimited; length register not counted.
// - Unlimited without sync: no address filter, Manchester or dewhitening.
// - Unlimited: no CRC check, no check-good, no payload-ready.
// - Preamble, sync and CRC stripped; only payload enters the FIFO.
// - Fixed format accepts exactly the configured byte count after sync.
// - Variable format loads byte counter from first byte after sync.
// - Length byte above configured maximum discards the packet.
// - Address byte must equal node id for reception to continue.
// - With check enabled, CRC is checked and check-good set on success.
// - Payload-ready asserted on gp output 0 once payload is in the FIFO.
// - FIFO stays readable after leaving receive mode.
// - CRC failure clears FIFO and withholds ready unless auto-clear disabled.
// - Check sequence uses the CCITT 16-bit polynomial.
// - Manchester select decodes payload and CRC, 10 to one, 01 to zero.
module rph_top (
  input wire logic ref_clk, // Core clock, 25 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic clk_en, // Freezes core state when low
  input wire logic link_clk, // Recovered bit clock
  input wire logic demod_raw, // Raw demodulator bit, pin domain
  input wire logic demod_clean, // Cleaned bit, link domain
  input wire logic packet_mode, // Packet mode selected
  input wire logic bitsync_enable, // Bit synchroniser enable
  input wire logic rx_mode, // Receiver active
  input wire logic sync_found, // Sync word matched, link domain level
  input wire logic sync_detect_enable, // Sync detection enabled
  input wire logic format_select, // 0 fixed/unlimited, 1 variable
  input wire logic [7:0] payload_len_cfg, // Length or maximum length
  input wire logic addr_check_en, // Address filtering enable
  input wire logic [7:0] own_node_id, // Node address
  input wire logic check_enable, // CRC check enable
  input wire logic auto_clear_disable, // Keep payload on CRC failure
  input wire logic aes_enable, // Decryption enabled
  input wire logic [1:0] dc_free_select, // DC-free coding select
  input wire logic fifo_rd, // Host FIFO read strobe
  output logic [7:0] fifo_rdata, // FIFO read data
  output logic fifo_not_empty, // FIFO holds data
  output logic gp_output_2, // Data pin
  output logic gp_output_1, // Data clock pin
  output logic gp_output_0, // Payload-ready event
  output logic check_good, // CRC good status
  output logic link_frame_active // Payload phase, link domain
);
  rph_byte_if byte_ch();
  rph_pkg::rph_state_e state_r;
  logic [1:0] raw_sync_r;
  logic raw_s2_r;
  logic bitsync_on;
  logic [2:0] tgl_sync_r;
  logic [2:0] end_sync_r;
  logic [1:0] manch_sync_r;
  logic manch_req;
  logic [7:0] cnt_r;
  logic [1:0] crc_cnt_r;
  logic unlimited;
  logic byte_stb;
  logic frame_end;
  logic [7:0] mem_r [rph_pkg::FIFO_DEPTH];
  logic [rph_pkg::FIFO_AW-1:0] wptr_r;
  logic [rph_pkg::FIFO_AW-1:0] rptr_r;
  logic [rph_pkg::FIFO_AW-1:0] pkt_start_r;
  logic fifo_wr;
  logic fifo_flush;
  logic crc_init;
  logic crc_upd;
  logic [15:0] crc_val;
  logic [7:0] max_len;
  logic [8:0] max_pl;
  logic rx_d_r;
  logic [1:0] act_sync_r;

  assign unlimited = !format_select && (payload_len_cfg == rph_pkg::FMT_FIXED);
  assign bitsync_on = bitsync_enable || packet_mode;
  assign manch_req = (dc_free_select == rph_pkg::DCF_MANCH) && packet_mode
                     && !(unlimited && !sync_detect_enable);
  assign max_len = aes_enable ? rph_pkg::MAX_MSG_AES : rph_pkg::MAX_LEN_PLAIN;
  // Nine bits so that the address allowance cannot wrap the 255 limit to zero
  assign max_pl = {1'b0, max_len} + 9'(addr_check_en);

  // Frame is active in link domain while sync holds in packet receive
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) link_frame_active <= 1'b0;
    else link_frame_active <= sync_found && packet_mode && rx_mode;
  end

  // Manchester select crosses into link domain
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) manch_sync_r <= 2'b00;
    else manch_sync_r <= {manch_sync_r[0], manch_req};
  end

  rph_link_rx u_link (
    .link_clk(link_clk),
    .rst_b(rst_b),
    .bit_in(demod_clean),
    .frame_active(link_frame_active),
    .manch_en(manch_sync_r[1]),
    .byte_o(byte_ch)
  );

  // Raw pin input synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_sync_r <= 2'b00;
      raw_s2_r <= 1'b0;
    end else if (clk_en) begin
      raw_sync_r <= {raw_sync_r[0], demod_raw};
      raw_s2_r <= raw_sync_r[1];
    end
  end

  // Continuous-mode pins: data on falling clock edge when synchronised
  always_ff @(negedge link_clk or negedge rst_b) begin
    if (!rst_b) gp_output_2 <= 1'b0;
    else if (packet_mode) gp_output_2 <= 1'b0;
    else if (bitsync_on) gp_output_2 <= demod_clean;
    else gp_output_2 <= raw_s2_r;
  end

  // Data clock pin is driven high only with bit sync in continuous mode
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) gp_output_1 <= 1'b0;
    else gp_output_1 <= bitsync_on && !packet_mode;
  end

  // Toggle crossings for bytes and frame end; data is stable at toggle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_sync_r <= 3'b000;
      end_sync_r <= 3'b000;
      act_sync_r <= 2'b00;
    end else if (clk_en) begin
      tgl_sync_r <= {tgl_sync_r[1:0], byte_ch.tgl};
      end_sync_r <= {end_sync_r[1:0], byte_ch.frame_end_tgl};
      act_sync_r <= {act_sync_r[0], link_frame_active};
    end
  end
  assign byte_stb = tgl_sync_r[2] ^ tgl_sync_r[1];
  assign frame_end = end_sync_r[2] ^ end_sync_r[1];

  // Packet state machine
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= rph_pkg::RPH_IDLE;
      cnt_r <= 8'h00;
      crc_cnt_r <= 2'h0;
    end else if (clk_en) begin
      unique case (state_r)
        rph_pkg::RPH_IDLE: begin
          crc_cnt_r <= 2'h0;
          if (act_sync_r[1] && packet_mode) begin
            if (format_select) state_r <= rph_pkg::RPH_LEN;
            else if (unlimited) state_r <= rph_pkg::RPH_DATA;
            else begin
              cnt_r <= payload_len_cfg;
              if ({1'b0, payload_len_cfg} > max_pl) state_r <= rph_pkg::RPH_DROP;
              else state_r <= addr_check_en ? rph_pkg::RPH_ADDR : rph_pkg::RPH_DATA;
            end
          end
        end
        rph_pkg::RPH_LEN: if (byte_stb) begin
          cnt_r <= byte_ch.data;
          if (byte_ch.data > payload_len_cfg || byte_ch.data < rph_pkg::MIN_VAR_LEN
              || {1'b0, byte_ch.data} > max_pl) state_r <= rph_pkg::RPH_DROP;
          else state_r <= addr_check_en ? rph_pkg::RPH_ADDR : rph_pkg::RPH_DATA;
        end
        rph_pkg::RPH_ADDR: if (byte_stb) begin
          cnt_r <= cnt_r - 8'h01;
          if (byte_ch.data != own_node_id) state_r <= rph_pkg::RPH_DROP;
          else if (cnt_r == 8'h01) state_r <= check_enable ? rph_pkg::RPH_CRC : rph_pkg::RPH_DONE;
          else state_r <= rph_pkg::RPH_DATA;
        end
        rph_pkg::RPH_DATA: begin
          if (unlimited && frame_end) state_r <= rph_pkg::RPH_IDLE;
          else if (byte_stb && !unlimited) begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
              crc_cnt_r <= 2'h0;
              state_r <= check_enable ? rph_pkg::RPH_CRC : rph_pkg::RPH_DONE;
            end
          end
        end
        rph_pkg::RPH_CRC: if (byte_stb) begin
          crc_cnt_r <= crc_cnt_r + 2'h1;
          if (crc_cnt_r == 2'h1) state_r <= rph_pkg::RPH_DONE;
        end
        rph_pkg::RPH_DONE: state_r <= rph_pkg::RPH_DROP;
        rph_pkg::RPH_DROP: if (!act_sync_r[1]) state_r <= rph_pkg::RPH_IDLE;
        default: state_r <= rph_pkg::RPH_IDLE;
      endcase
      if (!rx_mode) state_r <= rph_pkg::RPH_IDLE;
    end
  end

  // Payload bytes only enter the FIFO; CRC bytes feed only the checker
  assign fifo_wr = byte_stb && (state_r == rph_pkg::RPH_LEN || state_r == rph_pkg::RPH_ADDR
                   || state_r == rph_pkg::RPH_DATA);
  assign crc_init = state_r == rph_pkg::RPH_IDLE;
  assign crc_upd = fifo_wr || (byte_stb && state_r == rph_pkg::RPH_CRC);

  rph_crc16 u_crc (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(clk_en),
    .init(crc_init),
    .upd(crc_upd),
    .din(byte_ch.data),
    .crc(crc_val)
  );

  // Flush on entering receive, on filter reject, on CRC failure with auto-clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) rx_d_r <= 1'b0;
    else if (clk_en) rx_d_r <= rx_mode;
  end
  assign fifo_flush = (rx_mode && !rx_d_r)
                      || (state_r == rph_pkg::RPH_DONE && check_enable
                          && crc_val != rph_pkg::CRC_RESIDUE_OK && !auto_clear_disable);

  // CRC good status and payload ready event
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      check_good <= 1'b0;
      gp_output_0 <= 1'b0;
    end else if (clk_en) begin
      if (rx_mode && !rx_d_r) begin
        check_good <= 1'b0;
        gp_output_0 <= 1'b0;
      end else if (state_r == rph_pkg::RPH_DONE) begin
        check_good <= check_enable && crc_val == rph_pkg::CRC_RESIDUE_OK;
        gp_output_0 <= !check_enable || crc_val == rph_pkg::CRC_RESIDUE_OK
                       || auto_clear_disable;
      end else if (fifo_flush || (!fifo_not_empty && !rx_mode)) begin
        gp_output_0 <= 1'b0;
      end
    end
  end

  // Receive FIFO; read path survives leaving receive mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_r <= '0;
      rptr_r <= '0;
      pkt_start_r <= '0;
      fifo_rdata <= 8'h00;
      fifo_not_empty <= 1'b0;
    end else if (clk_en) begin
      if (fifo_flush || (state_r == rph_pkg::RPH_DROP && wptr_r != pkt_start_r && !gp_output_0)) begin
        // Pointers are linear, so a flush restarts them to regain the full depth
        wptr_r <= '0;
        rptr_r <= '0;
        pkt_start_r <= '0;
        fifo_not_empty <= 1'b0;
      end else begin
        if (fifo_wr && wptr_r != rph_pkg::FIFO_AW'(rph_pkg::FIFO_DEPTH)) begin
          wptr_r <= wptr_r + 1'b1;
        end
        if (fifo_rd && fifo_not_empty) begin
          fifo_rdata <= mem_r[rptr_r];
          rptr_r <= rptr_r + 1'b1;
        end
        fifo_not_empty <= (wptr_r + rph_pkg::FIFO_AW'(fifo_wr)) != (rptr_r + rph_pkg::FIFO_AW'(fifo_rd && fifo_not_empty));
        if (state_r == rph_pkg::RPH_IDLE) pkt_start_r <= wptr_r;
      end
    end
  end

  // Storage array, written only while there is room; no reset needed
  always_ff @(posedge ref_clk) begin
    if (clk_en && fifo_wr && wptr_r != rph_pkg::FIFO_AW'(rph_pkg::FIFO_DEPTH)) begin
      mem_r[wptr_r] <= byte_ch.data;
    end
  end
endmodule

// [hw/rph_pkg.sv]
// Package of constants and types for the receive packet handler
package rph_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [7:0] FMT_FIXED = 8'h00;
  localparam logic [7:0] MAX_LEN_PLAIN = 8'hFF;
  localparam logic [7:0] MAX_MSG_AES = 8'h40;
  localparam logic [7:0] MIN_VAR_LEN = 8'h01;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h1D0F;
  localparam logic [15:0] CRC_RESIDUE_OK = 16'h0000;
  localparam logic [1:0] DCF_MANCH = 2'h1;
  localparam int FIFO_DEPTH = 66;
  localparam int FIFO_AW = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    RPH_IDLE = 3'b000,
    RPH_LEN  = 3'b001,
    RPH_ADDR = 3'b011,
    RPH_DATA = 3'b010,
    RPH_CRC  = 3'b110,
    RPH_DONE = 3'b111,
    RPH_DROP = 3'b101
  } rph_state_e;
endpackage

// [hw/rph_byte_if.sv]
// Interface carrying assembled bytes from the link domain to the core
interface rph_byte_if;
  logic [7:0] data;
  logic tgl;
  logic frame_end_tgl;
  modport src(output data, output tgl, output frame_end_tgl);
  modport dst(input data, input tgl, input frame_end_tgl);
endinterface

// [hw/rph_link_rx.sv]
// Link-domain bit handling: Manchester decode and byte assembly
module rph_link_rx (
  input wire logic link_clk, // Recovered bit clock
  input wire logic rst_b, // Async reset, active low
  input wire logic bit_in, // Cleaned demodulator bit
  input wire logic frame_active, // Payload phase, link-domain level
  input wire logic manch_en, // Manchester decoding enabled
  rph_byte_if.src byte_o // Byte toggle channel
);
  logic [7:0] shift_r;
  logic [2:0] cnt_r;
  logic half_r;
  logic first_chip_r;
  logic act_r;
  logic [7:0] data_r;
  logic tgl_r;
  logic end_tgl_r;
  logic dec_valid;
  logic dec_bit;

  // Manchester pairs: 10 gives one, 01 gives zero
  always_comb begin
    dec_valid = manch_en ? half_r : 1'b1;
    dec_bit = manch_en ? first_chip_r : bit_in;
  end

  // Chip pairing
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_r <= 1'b0;
      first_chip_r <= 1'b0;
    end else if (!frame_active) begin
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
      first_chip_r <= bit_in;
    end
  end

  // MSB-first byte assembly
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= 8'h00;
      cnt_r <= 3'h0;
      data_r <= 8'h00;
      tgl_r <= 1'b0;
    end else if (!frame_active) begin
      cnt_r <= 3'h0;
    end else if (dec_valid) begin
      shift_r <= {shift_r[6:0], dec_bit};
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == rph_pkg::BIT_LAST) begin
        data_r <= {shift_r[6:0], dec_bit};
        tgl_r <= ~tgl_r;
      end
    end
  end

  // Frame end marker on falling frame_active
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_r <= 1'b0;
      end_tgl_r <= 1'b0;
    end else begin
      act_r <= frame_active;
      if (act_r && !frame_active) end_tgl_r <= ~end_tgl_r;
    end
  end

  assign byte_o.data = data_r;
  assign byte_o.tgl = tgl_r;
  assign byte_o.frame_end_tgl = end_tgl_r;
endmodule

// [hw/rph_crc16.sv]
// CCITT 16-bit checker, one byte per update
module rph_crc16 (
  input wire logic ref_clk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic init, // Restart the checker
  input wire logic upd, // Absorb one byte
  input wire logic [7:0] din, // Byte to absorb
  output logic [15:0] crc // Running remainder
);
  logic [15:0] nxt;

  // Bitwise polynomial division, MSB first
  always_comb begin
    nxt = crc;
    for (int i = 7; i >= 0; i--) begin
      if (nxt[15] ^ din[i]) nxt = {nxt[14:0], 1'b0} ^ rph_pkg::CRC_POLY;
      else nxt = {nxt[14:0], 1'b0};
    end
  end

  // Remainder register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) crc <= rph_pkg::CRC_INIT;
    else if (ce) begin
      if (init) crc <= rph_pkg::CRC_INIT;
      else if (upd) crc <= nxt;
    end
  end
endmodule

// [dv/rph_top_assertions.sv]
// Port-level assertions for the receive packet handler
module rph_top_checker (
  input wire logic ref_clk, // Core clock
  input wire logic rst_b, // Reset, low
  input wire logic packet_mode, // Packet mode
  input wire logic bitsync_enable, // Bit sync
  input wire logic rx_mode, // Receiver on
  input wire logic format_select, // Format bit
  input wire logic [7:0] payload_len_cfg, // Length cfg
  input wire logic check_enable, // CRC on
  input wire logic auto_clear_disable, // Keep on fail
  input wire logic demod_raw, // Raw bit
  input wire logic fifo_rd, // Pop
  input wire logic fifo_not_empty, // FIFO has data
  input wire logic gp_output_2, // Data pin
  input wire logic gp_output_1, // Clock pin
  input wire logic gp_output_0, // Ready
  input wire logic check_good // CRC good
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // Raw bit held steady in continuous mode without bit sync
  sequence raw_path_s;
    (!packet_mode && !bitsync_enable && rx_mode && $stable(demod_raw))[*6];
  endsequence
  // Ready event rising
  sequence rdy_rise_s;
    $rose(gp_output_0);
  endsequence
  raw_pin_a: assert property (raw_path_s |-> gp_output_2 == demod_raw)
    else $error("data pin not raw bit");
  no_dclk_a: assert property ((!packet_mode && !bitsync_enable)[*2] |-> !gp_output_1)
    else $error("clock pin without bit sync");
  dclk_on_a: assert property ((!packet_mode && bitsync_enable && rx_mode)[*3] |-> gp_output_1)
    else $error("clock pin missing");
  pkt_pin_a: assert property (packet_mode[*4] |-> !gp_output_2)
    else $error("data pin busy in packet mode");
  rdy_fmt_a: assert property (rdy_rise_s |-> packet_mode && (format_select || payload_len_cfg != 8'h00))
    else $error("ready in unlimited format");
  rdy_data_a: assert property (rdy_rise_s |-> ##[0:2] fifo_not_empty)
    else $error("ready with empty FIFO");
  rdy_crc_a: assert property (rdy_rise_s ##0 (check_enable && !auto_clear_disable) |-> check_good)
    else $error("ready after failed check");
  good_en_a: assert property ($rose(check_good) |-> check_enable && (format_select || payload_len_cfg != 8'h00))
    else $error("check good without check");
  fifo_keep_a: assert property ((fifo_not_empty && !rx_mode && !fifo_rd) ##1 !rx_mode |-> fifo_not_empty)
    else $error("FIFO lost outside rx");
endmodule

bind rph_top rph_top_checker u_chk (.*);

// [dv/rph_host.sv]
// Host model: pops the receive FIFO and samples the data pin
module rph_host (
  input wire logic ref_clk, // Core clock
  input wire logic link_clk, // Bit clock
  input wire logic [7:0] fifo_rdata, // Read data
  input wire logic fifo_not_empty, // FIFO has data
  input wire logic gp_output_2, // Data pin
  output logic fifo_rd // Pop strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic data_bit = 1'b0; // Last sampled data pin
  initial fifo_rd = 1'b0;
  // Data is taken on the rising bit clock, it moves on the falling one
  always @(posedge link_clk) data_bit <= gp_output_2;
  // One pop per two cycles so the status flag has settled
  task automatic drain(output logic [7:0] q[$]);
    int n;
    q = {};
    n = 0;
    while (fifo_not_empty === 1'b1 && n < 80) begin
      fifo_rd = 1'b1;
      @(posedge ref_clk) #2 fifo_rd = 1'b0;
      q.push_back(fifo_rdata);
      @(posedge ref_clk) #2 n++;
    end
  endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the receive packet handler
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rst_b = 1'b0, link_clk = 1'b0, demod_raw = 1'b0, demod_clean = 1'b0;
  logic packet_mode = 1'b0, bitsync_enable = 1'b0, rx_mode = 1'b0, sync_found = 1'b0;
  logic sync_detect_enable = 1'b1, format_select = 1'b0, addr_check_en = 1'b0;
  logic check_enable = 1'b0, auto_clear_disable = 1'b0, fifo_rd;
  logic [7:0] payload_len_cfg = 8'h00, own_node_id = 8'h00, fifo_rdata;
  logic [1:0] dc_free_select = 2'h0;
  logic clk_en = 1'b1, aes_enable = 1'b0;
  logic fifo_not_empty, gp_output_2, gp_output_1, gp_output_0, check_good, link_frame_active;
  logic [31:0] seed = 32'h7EFFEFFE;
  logic [7:0] pl[$], tx[$], got[$], exp_q[$];
  int errors = 0;
  int n_compared = 0;
  rph_top DUT (.*);
  rph_host host (.ref_clk, .link_clk, .fifo_rdata, .fifo_not_empty, .gp_output_2, .fifo_rd);
  // 25 MHz core clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference check sequence, MSB first over whole bytes
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = rph_pkg::CRC_INIT;
    foreach (q[i])
      for (int k = 7; k >= 0; k--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][k]) ? rph_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One 15 ns bit clock period; data moves while the clock is low, clear of the falling edge
  task automatic chip(input logic v);
    #2 demod_clean = v;
    #5.5 link_clk = 1'b1;
    #7.5 link_clk = 1'b0;
  endtask
  // Link side: two lead chips let the decode select cross, the last sync chip opens the frame
  task automatic send_frame(input logic man);
    chip(1'b1);
    chip(1'b0);
    sync_found = 1'b1;
    chip(1'b1);
    foreach (tx[i])
      for (int k = 7; k >= 0; k--) begin
        chip(tx[i][k] ^ 1'b0);
        if (man) chip(!tx[i][k]);
      end
    sync_found = 1'b0;
    chip(!demod_clean);
    chip(!demod_clean);
  endtask
  task automatic mk(input int n);
    pl = {};
    repeat (n) begin
      seed = lfsr(seed);
      pl.push_back(seed[7:0]);
    end
  endtask
  // One packet against the model: expected FIFO bytes, ready and check flags
  task automatic pkt(input logic fs, ac, ce, acd, man, bad, input logic [7:0] len);
    logic [15:0] c;
    logic unl, drop;
    unl = !fs && len == 8'h00;
    c = crc16(pl);
    c[0] = c[0] ^ bad;
    tx = pl;
    if (ce && !unl) begin
      tx.push_back(c[15:8]);
      tx.push_back(c[7:0]);
    end
    drop = (fs && (pl[0] > len || pl[0] == 8'h00)) || (ac && !unl && pl[fs] !== own_node_id);
    drop = drop || (aes_enable && !unl && (fs ? pl[0] : len) > rph_pkg::MAX_MSG_AES + 8'(ac));
    drop = drop || (ce && bad && !acd && !unl);
    exp_q = pl;
    if (drop) exp_q = {};
    format_select = fs;
    payload_len_cfg = len;
    addr_check_en = ac;
    check_enable = ce;
    auto_clear_disable = acd;
    dc_free_select = {1'b0, man};
    sync_detect_enable = !unl;
    @(posedge ref_clk) #2 rx_mode = 1'b1;
    repeat (4) @(posedge ref_clk);
    #2 send_frame(man);
    repeat (8) @(posedge ref_clk);
    #2 chk(gp_output_0, !unl && !drop);
    chk(check_good, !unl && !drop && ce && !bad);
    rx_mode = 1'b0;
    host.drain(got);
    chk(8'(got.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) chk(got[i], exp_q[i]);
    $display("packet test done, %0d bytes", got.size());
  endtask
  // Watchdog, far beyond the few tens of microseconds needed
  initial begin
    #2ms;
    errors++;
    close_out();
  end
  initial begin
    logic prev;
    repeat (16) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    seed = lfsr(seed);
    own_node_id = seed[15:8];
    repeat (3) @(posedge ref_clk);
    #2 rx_mode = 1'b1;
    // Continuous mode: raw bits without bit sync, then cleaned bits with it
    repeat (8) begin
      seed = lfsr(seed);
      demod_raw = seed[0];
      // The pin register moves on the bit clock; 16 chips span six core cycles
      repeat (16) chip(demod_clean);
      chk(gp_output_2, demod_raw);
      chk(gp_output_1, 1'b0);
    end
    bitsync_enable = 1'b1;
    for (int i = 0; i < 9; i++) begin
      prev = demod_clean;
      seed = lfsr(seed);
      chip(seed[3]);
      if (i > 0) chk(host.data_bit, prev);
    end
    repeat (3) @(posedge ref_clk);
    #2 chk(gp_output_1, 1'b1);
    rx_mode = 1'b0;
    bitsync_enable = 1'b0;
    packet_mode = 1'b1;
    // Let the pin registers see packet mode on the bit clock
    chip(1'b0);
    chip(1'b0);
    $display("continuous test done");
    // Packet cases: fixed, variable, Manchester, filters, check failures, unlimited
    mk(5);
    pl[0] = own_node_id;
    pkt(0, 1, 1, 0, 0, 0, 8'h05);
    mk(4);
    pl[0] = 8'h03;
    pl[1] = own_node_id;
    pkt(1, 1, 1, 0, 1, 0, 8'h03);
    mk(5);
    pl[0] = 8'h04;
    pkt(1, 0, 1, 0, 0, 0, 8'h03);
    mk(3);
    pl[0] = ~own_node_id;
    pkt(0, 1, 1, 0, 0, 0, 8'h03);
    mk(4);
    pkt(0, 0, 1, 0, 0, 1, 8'h04);
    mk(4);
    pkt(0, 0, 1, 1, 0, 1, 8'h04);
    mk(6);
    pl[0] = ~own_node_id;
    pkt(0, 1, 1, 0, 0, 0, 8'h00);
    mk(2);
    pl[0] = 8'h01;
    pkt(1, 0, 0, 0, 0, 0, 8'h05);
    mk(1);
    pkt(0, 0, 0, 0, 0, 0, 8'h01);
    mk(2);
    pl[0] = 8'h00;
    pkt(1, 0, 0, 0, 0, 0, 8'h05);
    aes_enable = 1'b1;
    mk(3);
    pl[0] = 8'h41;
    pkt(1, 0, 1, 0, 0, 0, 8'hFF);
    close_out();
  end
endmodule
